// ---- rtl/wfd_top.v ----
// Functional notes
// R1: Sync run, then sixteen station address copies.
// R2: Sync run is six 0xff bytes.
// R3: Any byte position; plain byte scan. Code scans only from byte 12 on, after the header.
// R4: Copies contiguous; other bytes restart.
// R5: Scan only while port mask bit 2 set.
// R6: Own and broadcast frames scanned.
// R7: Needs good addresses and CRC.
// R8: No pattern, no event.
// R9: Pattern drives wake output.
// R10: Link up is a wake event.
// R11: Mask 0x7d bits 3..0 gate interrupt.
// R12: Status 0x7c bits 3..0 record events.
// R13: Status read clears returned bits.
// R14: Mask 0x7d bit 4 gates wake output.
// R15: Status 0x7c bit 4 flags wake, read clears.
// R16: Host reacts to outputs, no polling.
// R17: Management pins reach PHY sets only.
// R18: Port status bit 0: energy.
// R19: Port status bit 1: link up.
// R20: Port status bit 2: wake frame.
// R21: Outputs low while enabled status set.
// R22: Event beats coinciding clearing read.
//
// Purpose: Wake event detection and interrupt/wake outputs of the switch.
// Assumes: link_up is on this clock;
//          energy_det is asynchronous.
// Notes:   Receive bytes pass through a two-entry buffer and are scanned
//          as they leave it.
`timescale 1ns/1ps
`include "wfd_regs.vh"

module wfd_top #(
    parameter DW = 8
) (
    input  wire                     clk,
    input  wire                     rstn,
    input  wire [47:0]              station_addr,
    input  wire                     rx_valid,
    output wire                     rx_ready,
    input  wire [DW-1:0]            rx_data,
    input  wire [`WFD_PORT_W-1:0]   rx_port,
    input  wire                     rx_sof,
    input  wire                     rx_eof,
    input  wire                     rx_crc_ok,
    output wire                     tx_valid,
    input  wire                     tx_ready,
    output wire [DW-1:0]            tx_data,
    output wire [`WFD_PORT_W-1:0]   tx_port,
    output wire                     tx_sof,
    output wire                     tx_eof,
    output wire                     tx_crc_ok,
    input  wire [`WFD_NPORT-1:0]    link_up,
    input  wire [`WFD_NPORT-1:0]    energy_det,
    input  wire                     reg_cs,
    input  wire                     reg_wr,
    input  wire [7:0]               reg_addr,
    input  wire [7:0]               reg_wdata,
    output wire [7:0]               reg_rdata,
    output wire                     int_out_n,
    output wire                     wake_out_n
);

    localparam BW = DW + `WFD_PORT_W + 3;
    localparam PW = `WFD_NPORT * `WFD_PB_W;

    // ---------------------------------------------------------------------
    // Two-entry receive buffer
    // ---------------------------------------------------------------------
    reg  [BW-1:0] d0_r;
    reg  [BW-1:0] d1_r;
    reg  [1:0]    cnt_r;
    reg  [1:0]    cnt_nxt;
    reg           out_vld_r;
    reg           in_rdy_r;
    wire          push;
    wire          pop;
    wire [BW-1:0] in_word;

    assign in_word = {rx_port, rx_sof, rx_eof, rx_crc_ok, rx_data};
    assign push    = rx_valid & in_rdy_r;
    assign pop     = out_vld_r & tx_ready;

    always @* begin
        cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    end

    // A stalled receiver fills both slots; ready then drops so no byte is
    // lost, at the price of one idle cycle when the buffer reopens.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            d0_r      <= {BW{1'b0}};
            d1_r      <= {BW{1'b0}};
            cnt_r     <= 2'h0;
            out_vld_r <= 1'b0;
            in_rdy_r  <= 1'b0;
        end else begin
            if (pop)
                d0_r <= d1_r;
            if (push) begin
                if (cnt_r - {1'b0, pop} == 2'h0)
                    d0_r <= in_word;
                else
                    d1_r <= in_word;
            end
            cnt_r     <= cnt_nxt;
            out_vld_r <= (cnt_nxt != 2'h0);
            in_rdy_r  <= (cnt_nxt != 2'h2);
        end
    end

    assign rx_ready  = in_rdy_r;
    assign tx_valid  = out_vld_r;
    assign tx_data   = d0_r[DW-1:0];
    assign tx_crc_ok = d0_r[DW];
    assign tx_eof    = d0_r[DW+1];
    assign tx_sof    = d0_r[DW+2];
    assign tx_port   = d0_r[BW-1:DW+3];

    // ---------------------------------------------------------------------
    // Event sources
    // ---------------------------------------------------------------------
    reg  [`WFD_NPORT-1:0] en_s1_r;
    reg  [`WFD_NPORT-1:0] en_s2_r;
    reg  [`WFD_NPORT-1:0] en_s3_r;
    reg  [`WFD_NPORT-1:0] lk_d_r;
    reg  [PW-1:0]         pmask_r;
    wire [`WFD_NPORT-1:0] hit;
    wire [PW-1:0]         ev;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            en_s1_r <= {`WFD_NPORT{1'b0}};
            en_s2_r <= {`WFD_NPORT{1'b0}};
            en_s3_r <= {`WFD_NPORT{1'b0}};
            lk_d_r  <= {`WFD_NPORT{1'b0}};
        end else begin
            en_s1_r <= energy_det;
            en_s2_r <= en_s1_r;
            en_s3_r <= en_s2_r;
            lk_d_r  <= link_up;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `WFD_NPORT; g = g + 1) begin : port
            wfd_scan u_scan (
                .clk     (clk),
                .rstn    (rstn),
                .en      (pmask_r[g*`WFD_PB_W+`WFD_PB_FRAME]), // see R5
                .vld     (pop & (tx_port == g)),
                .data    (tx_data[7:0]),
                .sof     (tx_sof),
                .eof     (tx_eof),
                .crc_ok  (tx_crc_ok),
                .station (station_addr),
                .hit     (hit[g])
            );
            assign ev[g*`WFD_PB_W+`WFD_PB_ENERGY] =          // see R18
                en_s2_r[g] & ~en_s3_r[g] &
                pmask_r[g*`WFD_PB_W+`WFD_PB_ENERGY];
            assign ev[g*`WFD_PB_W+`WFD_PB_LINK] =            // see R10 see R19
                link_up[g] & ~lk_d_r[g] &
                pmask_r[g*`WFD_PB_W+`WFD_PB_LINK];
            assign ev[g*`WFD_PB_W+`WFD_PB_FRAME] = hit[g];   // see R20
        end
    endgenerate

    // ---------------------------------------------------------------------
    // Register decode
    // ---------------------------------------------------------------------
    // Returns {hit, port index} for a per-port register bank.
    function [`WFD_PORT_W:0] preg;
        input [7:0] a;
        input [7:0] base;
        reg   [7:0] d;
        begin
            d    = a - base;
            preg = {(a >= base) && (d < `WFD_PREG_SPAN),
                    d[`WFD_PORT_W-1:0]};
        end
    endfunction

    reg  [`WFD_ISTAT_W-1:0] istat_r;
    reg  [`WFD_ISTAT_W-1:0] imask_r;
    reg  [PW-1:0]           pstat_r;
    reg  [7:0]              rdata_r;
    reg                     int_n_r;
    reg                     wake_n_r;
    reg  [7:0]              rd_val;
    reg  [`WFD_ISTAT_W-1:0] iclr;
    reg  [PW-1:0]           pclr;
    reg  [`WFD_ISTAT_W-1:0] iset;
    reg  [`WFD_ISTAT_W-1:0] istat_nxt;
    reg  [PW-1:0]           pstat_nxt;
    reg  [`WFD_PORT_W:0]    pm_dec;
    reg  [`WFD_PORT_W:0]    ps_dec;
    wire                    rd;
    wire                    wr;
    integer                 i;

    // Only the serial configuration path reaches this map.
    assign rd = reg_cs & ~reg_wr; // see R17
    assign wr = reg_cs & reg_wr;

    always @* begin
        pm_dec = preg(reg_addr, `WFD_REG_PMASK0);
        ps_dec = preg(reg_addr, `WFD_REG_PSTAT0);
        rd_val = 8'h00;
        iclr   = {`WFD_ISTAT_W{1'b0}};
        pclr   = {PW{1'b0}};
        iset   = {`WFD_ISTAT_W{1'b0}};
        if (reg_addr == `WFD_REG_ISTAT) begin
            rd_val = {3'h0, istat_r};
            if (rd)
                iclr = istat_r; // see R13 see R15
        end else if (reg_addr == `WFD_REG_IMASK) begin
            rd_val = {3'h0, imask_r};
        end
        for (i = 0; i < `WFD_NPORT; i = i + 1) begin
            if (pm_dec[`WFD_PORT_W] && pm_dec[`WFD_PORT_W-1:0] == i)
                rd_val = {5'h00, pmask_r[i*`WFD_PB_W +: `WFD_PB_W]};
            if (ps_dec[`WFD_PORT_W] && ps_dec[`WFD_PORT_W-1:0] == i) begin
                rd_val = {5'h00, pstat_r[i*`WFD_PB_W +: `WFD_PB_W]};
                if (rd)
                    pclr[i*`WFD_PB_W +: `WFD_PB_W] =
                        pstat_r[i*`WFD_PB_W +: `WFD_PB_W];
            end
            iset[i] = |ev[i*`WFD_PB_W +: `WFD_PB_W]; // see R12
        end
        iset[`WFD_IB_WAKE] = |ev; // see R9 see R15
        // Set is applied after clear so a coincident event survives.
        istat_nxt = (istat_r & ~iclr) | iset; // see R22
        pstat_nxt = (pstat_r & ~pclr) | ev;   // see R22
    end

    // ---------------------------------------------------------------------
    // Registers and outputs
    // ---------------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            istat_r  <= `WFD_ISTAT_RST;
            imask_r  <= `WFD_IMASK_RST;
            pstat_r  <= {PW{1'b0}};
            pmask_r  <= {`WFD_NPORT{`WFD_PMASK_RST}};
            rdata_r  <= 8'h00;
            int_n_r  <= 1'b1;
            wake_n_r <= 1'b1;
        end else begin
            istat_r <= istat_nxt;
            pstat_r <= pstat_nxt;
            if (rd)
                rdata_r <= rd_val;
            if (wr && reg_addr == `WFD_REG_IMASK)
                imask_r <= reg_wdata[`WFD_ISTAT_W-1:0];
            for (i = 0; i < `WFD_NPORT; i = i + 1) begin
                if (wr && pm_dec[`WFD_PORT_W] &&
                    pm_dec[`WFD_PORT_W-1:0] == i)
                    pmask_r[i*`WFD_PB_W +: `WFD_PB_W] <=
                        reg_wdata[`WFD_PB_W-1:0];
            end
            // Levels, not pulses: they stay low until the host reads the
            // status, so a missed edge on the host side loses nothing.
            int_n_r  <= ~|(istat_r[`WFD_IRQ_W-1:0] &
                           imask_r[`WFD_IRQ_W-1:0]); // see R11 see R21
            wake_n_r <= ~(istat_r[`WFD_IB_WAKE] &
                          imask_r[`WFD_IB_WAKE]);    // see R14 see R21
        end
    end

    assign reg_rdata  = rdata_r;
    assign int_out_n  = int_n_r;
    assign wake_out_n = wake_n_r;

endmodule

// ---- pkg/wfd_regs.vh ----
// Purpose: Register map, field positions and pattern constants of the
//          wake frame detector and its interrupt/wake outputs.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef WFD_REGS_VH
`define WFD_REGS_VH

// -------------------------------------------------------------------------
// Register offsets
// -------------------------------------------------------------------------
`define WFD_REG_ISTAT   8'h7c
`define WFD_REG_IMASK   8'h7d
`define WFD_REG_PMASK0  8'h80
`define WFD_REG_PSTAT0  8'h84
`define WFD_PREG_SPAN   8'h04

// -------------------------------------------------------------------------
// Fields and reset values
// -------------------------------------------------------------------------
`define WFD_PB_ENERGY   0
`define WFD_PB_LINK     1
`define WFD_PB_FRAME    2
`define WFD_PB_W        3
`define WFD_IB_WAKE     4
`define WFD_IRQ_W       4
`define WFD_ISTAT_W     5
`define WFD_NPORT       4
`define WFD_PORT_W      2
`define WFD_ISTAT_RST   5'h00
`define WFD_IMASK_RST   5'h00
`define WFD_PMASK_RST   3'h0

// -------------------------------------------------------------------------
// Wake pattern and frame header
// -------------------------------------------------------------------------
`define WFD_SYNC_BYTE   8'hff
`define WFD_SYNC_LEN    3'h6
`define WFD_ADDR_BYTES  3'h6
`define WFD_ADDR_REPS   5'h10
`define WFD_DA_LEN      4'h6
`define WFD_SA_POS      4'h6
`define WFD_HDR_LEN     4'hc

`endif

// ---- rtl/wfd_scan.v ----
// Purpose: Byte scanner that flags one port's wake frame at frame end.
// Assumes: Bytes arrive one per valid cycle, sof on the first byte, eof
//          and crc_ok on the last.
// Notes:   Destination bytes and the source group bit are checked; header bytes are never searched for the pattern.
`timescale 1ns/1ps
`include "wfd_regs.vh"

module wfd_scan (
    input  wire        clk,
    input  wire        rstn,
    input  wire        en,
    input  wire        vld,
    input  wire [7:0]  data,
    input  wire        sof,
    input  wire        eof,
    input  wire        crc_ok,
    input  wire [47:0] station,
    output wire        hit
);

    reg  [3:0] hdr_r;
    reg        dan_r;
    reg        dab_r;
    reg        sao_r;
    reg  [2:0] syn_r;
    reg  [2:0] bs_r;
    reg  [4:0] rp_r;
    reg        fnd_r;
    reg        hit_r;
    reg  [3:0] pos;
    reg        dan;
    reg        dab;
    reg        sao;
    reg  [2:0] syn;
    reg  [2:0] bs;
    reg  [4:0] rp;
    reg        fnd;
    reg  [3:0] hdr_nxt;
    reg        hit_nxt;
    wire       first;

    function [7:0] stn_byte;
        input [47:0] a;
        input [2:0]  sel;
        begin
            case (sel)
                3'h0:    stn_byte = a[47:40];
                3'h1:    stn_byte = a[39:32];
                3'h2:    stn_byte = a[31:24];
                3'h3:    stn_byte = a[23:16];
                3'h4:    stn_byte = a[15:8];
                default: stn_byte = a[7:0];
            endcase
        end
    endfunction

    // A disabled scanner is held in its frame start state.
    assign first = (vld & sof) | ~en; // see R5
    assign hit   = hit_r;

    // ---------------------------------------------------------------------
    // Pattern search
    // ---------------------------------------------------------------------
    always @* begin
        pos     = first ? 4'h0 : hdr_r;
        dan     = first ? 1'b1 : dan_r;
        dab     = first ? 1'b1 : dab_r;
        sao     = first ? 1'b0 : sao_r;
        syn     = first ? 3'h0 : syn_r;
        bs      = first ? 3'h0 : bs_r;
        rp      = first ? 5'h00 : rp_r;
        fnd     = first ? 1'b0 : fnd_r;
        hdr_nxt = hdr_r;
        hit_nxt = 1'b0;
        if (!en) begin
            hdr_nxt = 4'h0;
        end else if (vld) begin
            hdr_nxt = (pos < `WFD_HDR_LEN) ? pos + 4'h1 : pos;
            if (pos < `WFD_DA_LEN) begin // see R6
                dan = dan & (data == stn_byte(station, pos[2:0]));
                dab = dab & (data == `WFD_SYNC_BYTE);
            end
            if (pos == `WFD_SA_POS)
                sao = ~data[0]; // see R7
            if (pos >= `WFD_HDR_LEN && !fnd) begin // see R3
                if (syn == `WFD_SYNC_LEN) begin
                    if (data == stn_byte(station, bs)) begin // see R1
                        if (bs == `WFD_ADDR_BYTES - 3'h1) begin
                            bs = 3'h0;
                            if (rp == `WFD_ADDR_REPS - 5'h01)
                                fnd = 1'b1;
                            rp = rp + 5'h01;
                        end else begin
                            bs = bs + 3'h1;
                        end
                    end else if (bs == 3'h0 && rp == 5'h00 &&
                                 data == `WFD_SYNC_BYTE) begin
                        syn = `WFD_SYNC_LEN;
                    end else begin // see R4
                        bs  = 3'h0;
                        rp  = 5'h00;
                        syn = (data == `WFD_SYNC_BYTE) ? 3'h1 : 3'h0;
                    end
                end else begin // see R2
                    syn = (data == `WFD_SYNC_BYTE) ? syn + 3'h1 : 3'h0;
                end
            end
            if (eof) begin // see R7 see R8
                hit_nxt = crc_ok & (dan | dab) & sao & fnd;
                hdr_nxt = 4'h0;
                fnd     = 1'b0;
                syn     = 3'h0;
                bs      = 3'h0;
                rp      = 5'h00;
            end
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hdr_r <= 4'h0;
            dan_r <= 1'b1;
            dab_r <= 1'b1;
            sao_r <= 1'b0;
            syn_r <= 3'h0;
            bs_r  <= 3'h0;
            rp_r  <= 5'h00;
            fnd_r <= 1'b0;
            hit_r <= 1'b0;
        end else begin
            hdr_r <= hdr_nxt;
            dan_r <= dan;
            dab_r <= dab;
            sao_r <= sao;
            syn_r <= syn;
            bs_r  <= bs;
            rp_r  <= rp;
            fnd_r <= fnd;
            hit_r <= hit_nxt;
        end
    end

endmodule

// ---- dv/wfd_props.sv ----
// Purpose: Port-level checks of the wake detector top module.
// Assumes: Bound to wfd_top; a single clock domain.
// Notes:   Mask copies follow the writes seen.
`timescale 1ns/1ps
`include "wfd_regs.vh"

module wfd_props #(
    parameter DW = 8
) (
    input wire          clk,
    input wire          rstn,
    input wire          rx_valid,
    input wire          rx_ready,
    input wire          tx_valid,
    input wire          tx_ready,
    input wire [DW-1:0] tx_data,
    input wire [1:0]    tx_port,
    input wire          tx_eof,
    input wire [3:0]    link_up,
    input wire          reg_cs,
    input wire          reg_wr,
    input wire [7:0]    reg_addr,
    input wire [7:0]    reg_wdata,
    input wire [7:0]    reg_rdata,
    input wire          int_out_n,
    input wire          wake_out_n
);
    // ---------------------------------------------------------------
    // Helper state
    // ---------------------------------------------------------------
    reg  [4:0] im_r;
    reg  [2:0] pm_r [0:3];
    reg  [2:0] occ_r;
    reg  [7:0] exp_rd;
    wire       rd = reg_cs && !reg_wr;
    wire       wr = reg_cs && reg_wr;
    wire [3:0] lk_en = {pm_r[3][1], pm_r[2][1], pm_r[1][1], pm_r[0][1]};
    integer    i;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            im_r <= 5'h00;
            occ_r <= 3'h0;
            for (i = 0; i < 4; i = i + 1) begin
                pm_r[i] <= 3'h0;
            end
        end else begin
            if (wr && reg_addr == `WFD_REG_IMASK) begin
                im_r <= reg_wdata[4:0];
            end
            if (wr && reg_addr[7:2] == 6'h20) begin
                pm_r[reg_addr[1:0]] <= reg_wdata[2:0];
            end
            occ_r <= occ_r + {2'h0, rx_valid && rx_ready}
                           - {2'h0, tx_valid && tx_ready};
        end
    end

    always @* begin
        exp_rd = (reg_addr == `WFD_REG_IMASK) ? {3'h0, im_r}
                                             : {5'h0, pm_r[reg_addr[1:0]]};
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    rdata_hold_a: assert property (!$past(rd) |-> $stable(reg_rdata))
        else $error("read data moved");
    unmapped_zero_a: assert property (rd && reg_addr[7:1] != 7'h3e
        && reg_addr[7:3] != 5'h10 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    mask_back_a: assert property (rd && (reg_addr == `WFD_REG_IMASK
        || reg_addr[7:2] == 6'h20) |=> reg_rdata == $past(exp_rd))
        else $error("mask readback wrong");
    pstat_width_a: assert property (rd && reg_addr[7:3] == 5'h10
        |=> reg_rdata[7:3] == 5'h00)
        else $error("port reg high bits");
    int_gate_a: assert property ($past(im_r[3:0]) == 4'h0 |-> int_out_n)
        else $error("int low while masked");
    wake_gate_a: assert property (!$past(im_r[4]) |-> wake_out_n)
        else $error("wake low while masked");
    link_irq_a: assert property (|(link_up & ~$past(link_up) & lk_en
        & im_r[3:0]) |-> ##[1:4] !int_out_n)
        else $error("link up no interrupt");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid
        && $stable(tx_data) && $stable(tx_port) && $stable(tx_eof))
        else $error("stalled byte changed");
    occupancy_a: assert property (occ_r <= 3'h2)
        else $error("buffer over two");
endmodule

// ---- dv/wfd_sink.sv ----
// Purpose: Downstream receiver of the detector's byte stream.
// Assumes: tx outputs are registered and change only at rising edges.
// Notes:   Slow mode stalls three cycles in four, so the buffer fills.
`timescale 1ns/1ps

module wfd_sink (
    input  wire        clk,
    input  wire        rstn,
    input  wire        slow,
    input  wire        tx_valid,
    input  wire [12:0] tx_word,
    output logic       tx_ready
);
    logic [12:0] got [$];
    logic        v_s;
    logic [12:0] w_s;

    initial tx_ready = 1'b0;
    // Registered outputs are steady at the falling edge, avoiding a race.
    always @(negedge clk) begin
        v_s = tx_valid;
        w_s = tx_word;
    end
    always @(posedge clk) begin
        if (v_s && tx_ready) begin
            got.push_back(w_s);
        end
        tx_ready <= #2 rstn && (!slow || $urandom % 4 == 0);
    end
endmodule

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench of the wake detector top module.
// Assumes: Inputs change 2 ns after the rising edge.
// Notes:   Expected wake results come from a byte scanning model below.
`timescale 1ns/1ps
`include "wfd_regs.vh"

module tb_top;
    logic        clk, rstn, rx_valid, rx_sof, rx_eof, rx_crc, reg_cs, reg_wr;
    logic        slow;
    logic [47:0] station;
    logic [7:0]  rx_data, reg_addr, reg_wdata, d;
    logic [1:0]  rx_port;
    logic [3:0]  link_up, energy_det;
    wire         rx_ready, tx_valid, tx_ready, tx_sof, tx_eof, tx_crc_ok;
    wire         int_out_n, wake_out_n;
    wire [7:0]   tx_data, reg_rdata;
    wire [1:0]   tx_port;
    integer      n_fail = 0, check_count = 0, cycles = 0, i, k;
    logic [7:0]  fq [$];
    logic [12:0] exq [$];
    logic [7:0]  ra [0:7] = '{8'h7c, 8'h7d, 8'h7e, 8'h80, 8'h83, 8'h84,
                              8'h87, 8'h10};

    wfd_top dut (.*, .station_addr(station), .rx_crc_ok(rx_crc));
    wfd_sink u_sink (.*,
        .tx_word({tx_port, tx_sof, tx_eof, tx_crc_ok, tx_data}));

    // ---------------------------------------------------------------
    // Clock, timeout and report
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            wrap_up;
        end
    end
    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [12:0] got, input logic [12:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    // ---------------------------------------------------------------
    // Drivers
    // ---------------------------------------------------------------
    task reg_w(input logic [7:0] a, input logic [7:0] w, input logic wr);
        @(posedge clk);
        #2;
        reg_cs = 1'b1;
        reg_wr = wr;
        reg_addr = a;
        reg_wdata = w;
        @(posedge clk);
        #2;
        reg_cs = 1'b0;
    endtask
    task reg_r(input logic [7:0] a, input logic [7:0] e);
        reg_w(a, 8'h00, 1'b0);
        chk({5'h0, reg_rdata}, {5'h0, e});
    endtask
    task send_byte(input logic [7:0] b, input logic s, input logic e,
                   input logic c, input logic [1:0] p);
        logic rdy;
        rx_valid = 1'b1;
        rx_data = b;
        rx_sof = s;
        rx_eof = e;
        rx_crc = c;
        rx_port = p;
        exq.push_back({p, s, e, c, b});
        rdy = 1'b0;
        while (!rdy) begin
            @(negedge clk);
            rdy = rx_ready;
            @(posedge clk);
        end
        #2;
    endtask

    // ---------------------------------------------------------------
    // Model of the wake pattern scan
    // ---------------------------------------------------------------
    function automatic logic exp_hit(input logic en, input logic c);
        integer j, s, m;
        logic h;
        logic [1:0] da;
        da = 2'b11;
        for (j = 0; j < 6; j++) begin
            if (fq[j] !== station[47-8*j -: 8]) da[0] = 1'b0;
            if (fq[j] !== 8'hff) da[1] = 1'b0;
        end
        h = 1'b0;
        s = 0;
        m = 0;
        for (j = 12; j < fq.size(); j++) begin
            if (m > 0 && fq[j] === station[47-8*(m%6) -: 8]) m++;
            else if (m > 0) begin
                m = 0;
                s = (fq[j] === 8'hff);
            end else if (fq[j] === 8'hff) s++;
            else if (s >= 6 && fq[j] === station[47:40]) begin
                m = 1;
                s = 0;
            end else s = 0;
            if (m == 96) h = 1'b1;
        end
        return h && en && c && (|da) && !fq[6][0];
    endfunction

    // Kinds: 0 own 1 bcast 2 crc 3 short 4 broken 5 sync 6 foreign
    // 7 off 8 group.
    task run_frame(input integer t);
        logic [1:0] p;
        logic h;
        integer j, n;
        p = 2'($urandom);
        reg_w(8'h80 + p, (t == 7) ? 8'h03 : 8'h04, 1'b1);
        fq.delete();
        for (j = 0; j < 6; j++)
            fq.push_back(t == 1 ? 8'hff : station[47-8*j -: 8] ^ 8'(t == 6));
        fq.push_back(8'(($urandom % 128) * 2 + (t == 8)));
        for (j = 0; j < 7; j++) fq.push_back(8'($urandom));
        n = $urandom % 12;
        for (j = 0; j < n; j++) fq.push_back(8'($urandom));
        n = (t == 5) ? 5 : 6 + $urandom % 2;
        for (j = 0; j < n; j++) fq.push_back(8'hff);
        for (j = 0; j < ((t == 3) ? 90 : 96); j++) begin
            if (t == 4 && j == 48) fq.push_back(8'h00);
            fq.push_back(station[47-8*(j%6) -: 8]);
        end
        fq.push_back(8'($urandom));
        for (j = 0; j < fq.size(); j++)
            send_byte(fq[j], j == 0, j == fq.size() - 1, t != 2, p);
        rx_valid = 1'b0;
        h = exp_hit(t != 7, t != 2);
        for (j = 0; j < 3000 && u_sink.got.size() < exq.size(); j++)
            @(posedge clk);
        repeat (4) @(posedge clk);
        #2;
        while (exq.size() > 0) chk(u_sink.got.pop_front(), exq.pop_front());
        chk(wake_out_n, !h);
        chk(int_out_n, !h);
        reg_r(8'h84 + p, h ? 8'h04 : 8'h00);
        reg_r(`WFD_REG_ISTAT, h ? 8'h10 | (8'h01 << p) : 8'h00);
        reg_r(`WFD_REG_ISTAT, 8'h00);
        chk(wake_out_n, 1'b1);
        reg_w(8'h80 + p, 8'h00, 1'b1);
        $display("test frame %0d done", t);
    endtask

    task ev_test(input integer e, input logic [4:0] im, input logic en);
        logic [1:0] p;
        p = 2'($urandom);
        reg_w(8'h80 + p, en ? 8'(1 << e) : 8'h00, 1'b1);
        reg_w(`WFD_REG_IMASK, {3'h0, im}, 1'b1);
        if (e == 1) link_up[p] = 1'b1;
        else energy_det[p] = 1'b1;
        repeat (8) @(posedge clk);
        #2;
        chk(int_out_n, !(en && im[p]));
        chk(wake_out_n, !(en && im[4]));
        reg_r(8'h84 + p, en ? 8'(1 << e) : 8'h00);
        reg_r(`WFD_REG_ISTAT, en ? 8'h10 | (8'h01 << p) : 8'h00);
        link_up[p] = 1'b0;
        energy_det[p] = 1'b0;
        reg_w(8'h80 + p, 8'h00, 1'b1);
        $display("test event %0d done", e);
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {rstn, rx_valid, rx_sof, rx_eof, rx_crc, reg_cs, reg_wr, slow} = 0;
        {rx_data, reg_addr, reg_wdata, rx_port, link_up, energy_det} = 0;
        void'($urandom(30942));
        station = {16'($urandom), 32'($urandom)} & 48'hfefe_fefe_fefe;
        repeat (12) @(posedge clk);
        #2;
        rstn = 1'b1;
        for (i = 0; i < 10; i++)
            reg_r(i < 2 ? 8'h7c + 8'(i) : 8'h7e + 8'(i), 8'h00);
        for (i = 0; i < 8; i++) begin
            d = 8'($urandom);
            reg_w(ra[i], d, 1'b1);
            reg_r(ra[i], ra[i] == 8'h7d ? d & 8'h1f :
                  ra[i][7:2] == 6'h20 ? d & 8'h07 : 8'h00);
            reg_w(ra[i], 8'h00, 1'b1);
        end
        $display("test registers done");
        for (k = 0; k < 18; k++) begin
            slow = k[0];
            reg_w(`WFD_REG_IMASK, 8'h1f, 1'b1);
            run_frame(k % 9);
        end
        for (k = 0; k < 2; k++) begin
            ev_test(k, 5'h1f, 1'b1);
            ev_test(k, 5'h00, 1'b1);
            ev_test(k, 5'h1f, 1'b0);
        end
        wrap_up;
    end
endmodule

bind wfd_top wfd_props #(.DW(DW)) u_props (.*);
